// ---- logic/lbr_pkg.sv ----
// package of constants, carriers and helpers for the large block ram
package lbr_pkg;
    // ==========================================================
    // array geometry
    localparam int LBR_TOTAL_BITS = 20480;
    localparam int LBR_ROW_W = 80;
    localparam int LBR_ROWS = LBR_TOTAL_BITS / LBR_ROW_W;
    localparam int LBR_ROW_AW = 8;
    localparam int LBR_WORD_W = 40;
    localparam int LBR_ADDR_W = 15;
    localparam int LBR_LANE_W = 6;
    localparam int LBR_BE_W = 4;
    localparam int LBR_BE_SLICE = 10;
    localparam int LBR_ECC_W = 33;
    localparam int LBR_TWO_PORT_MIN = 32;
    localparam int LBR_ZERO_CYCLES = LBR_ROWS;

    // ==========================================================
    // register map
    localparam logic [7:0] LBR_CFG_OFS = 8'h00;
    localparam logic [7:0] LBR_CTRL_OFS = 8'h04;
    localparam logic [7:0] LBR_STAT_OFS = 8'h08;
    localparam int LBR_CFG_WA_LSB = 0;
    localparam int LBR_CFG_WB_LSB = 3;
    localparam int LBR_CFG_ECC_BIT = 6;
    localparam int LBR_CFG_OREGA_BIT = 7;
    localparam int LBR_CFG_OREGB_BIT = 8;
    localparam int LBR_CFG_USED = 9;
    localparam int LBR_CTRL_PWR_BIT = 0;
    localparam int LBR_CTRL_ZERO_BIT = 1;
    localparam int LBR_ST_TWO_BIT = 0;
    localparam int LBR_ST_BUSY_BIT = 1;
    localparam int LBR_ST_PWR_BIT = 2;
    localparam int LBR_ST_SEC_BIT = 3;
    localparam int LBR_ST_DED_BIT = 4;
    localparam int LBR_ST_IGN_BIT = 5;
    localparam int LBR_ST_BAD_BIT = 6;
    localparam logic [LBR_CFG_USED-1:0] LBR_CFG_RST = 9'h000;
    localparam logic LBR_PWR_RST = 1'b1;

    // ==========================================================
    // types
    typedef enum logic [2:0] {
        LBR_W1, LBR_W2, LBR_W5, LBR_W10, LBR_W20, LBR_W32, LBR_W40, LBR_W33
    } lbr_width_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [LBR_ADDR_W-1:0] addr;
        logic [LBR_WORD_W-1:0] wdata;
        logic [LBR_BE_W-1:0] be;
    } lbr_req_t;

    typedef struct packed {
        logic valid;
        logic [LBR_WORD_W-1:0] data;
        logic sec;
        logic ded;
    } lbr_rsp_t;

    typedef struct packed {
        logic rd;
        logic we;
        logic [LBR_ROW_AW-1:0] row;
        logic [LBR_ROW_W-1:0] wdata;
        logic [LBR_ROW_W-1:0] wmask;
    } lbr_mem_port_t;

    // ==========================================================
    // helpers
    function automatic int lbr_bits(input lbr_width_t w);
        unique case (w)
            LBR_W1: return 1;
            LBR_W2: return 2;
            LBR_W5: return 5;
            LBR_W10: return 10;
            LBR_W20: return 20;
            LBR_W32: return 32;
            LBR_W40: return 40;
            LBR_W33: return 33;
        endcase
    endfunction : lbr_bits

    function automatic logic [39:0] lbr_put_mask(input lbr_width_t w, input logic [5:0] lane,
                                                 input logic [3:0] be);
        int n;
        int base;
        logic [39:0] m;
        n = lbr_bits(w);
        base = int'(lane) * n;
        m = '0;
        for (int i = 0; i < LBR_WORD_W; i++) begin
            if (i >= base && i < base + n) m[i] = be[(i - base) / LBR_BE_SLICE];
        end
        return m;
    endfunction : lbr_put_mask

    function automatic logic [39:0] lbr_put_data(input lbr_width_t w, input logic [5:0] lane,
                                                 input logic [39:0] d);
        int n;
        int base;
        logic [39:0] o;
        n = lbr_bits(w);
        base = int'(lane) * n;
        o = '0;
        for (int i = 0; i < LBR_WORD_W; i++) begin
            if (i >= base && i < base + n) o[i] = d[i - base];
        end
        return o;
    endfunction : lbr_put_data

    function automatic logic [39:0] lbr_get(input lbr_width_t w, input logic [5:0] lane,
                                            input logic [39:0] word);
        int n;
        int base;
        logic [39:0] o;
        n = lbr_bits(w);
        base = int'(lane) * n;
        o = '0;
        for (int i = 0; i < LBR_WORD_W; i++) begin
            if (i < n && base + i < LBR_WORD_W) o[i] = word[base + i];
        end
        return o;
    endfunction : lbr_get

    // two logical words share a row, bit by bit, so a double upset of
    // neighbouring cells lands as one error in each word
    function automatic logic [79:0] lbr_spread(input logic [39:0] word, input logic odd);
        logic [79:0] r;
        r = '0;
        for (int i = 0; i < LBR_WORD_W; i++) r[2 * i + int'(odd)] = word[i];
        return r;
    endfunction : lbr_spread

    function automatic logic [39:0] lbr_gather(input logic [79:0] row, input logic odd);
        logic [39:0] w;
        w = '0;
        for (int i = 0; i < LBR_WORD_W; i++) w[i] = row[2 * i + int'(odd)];
        return w;
    endfunction : lbr_gather

    // hamming positions 1..39 plus overall parity in bit 0
    function automatic logic [39:0] lbr_ecc_enc(input logic [32:0] d);
        logic [39:0] c;
        int k;
        c = '0;
        k = 0;
        for (int p = 1; p < LBR_WORD_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                c[p] = d[k];
                k = k + 1;
            end
        end
        for (int j = 0; j < 6; j++) begin
            for (int p = 1; p < LBR_WORD_W; p++) begin
                if ((p & (1 << j)) != 0 && p != (1 << j)) c[1 << j] = c[1 << j] ^ c[p];
            end
        end
        c[0] = ^c[39:1];
        return c;
    endfunction : lbr_ecc_enc

    // returns {double, single, data}
    function automatic logic [34:0] lbr_ecc_dec(input logic [39:0] cw);
        logic [39:0] c;
        logic [5:0] s;
        logic [32:0] d;
        logic sec;
        logic ded;
        int k;
        c = cw;
        s = '0;
        d = '0;
        sec = 1'b0;
        ded = 1'b0;
        k = 0;
        for (int p = 1; p < LBR_WORD_W; p++) begin
            if (c[p]) s = s ^ 6'(p);
        end
        if (s != '0 && ^c) begin
            if (int'(s) < LBR_WORD_W) begin
                c[s] = ~c[s];
                sec = 1'b1;
            end else begin
                ded = 1'b1;
            end
        end else if (s != '0) begin
            ded = 1'b1;
        end else if (^c) begin
            sec = 1'b1;
        end
        for (int p = 1; p < LBR_WORD_W; p++) begin
            if ((p & (p - 1)) != 0) begin
                d[k] = c[p];
                k = k + 1;
            end
        end
        return {ded, sec, d};
    endfunction : lbr_ecc_dec
endpackage : lbr_pkg

// ---- logic/lbr_mem.sv ----
// storage array of the large block ram with registered read rows
`timescale 1ns/100ps
module lbr_mem
    import lbr_pkg::*;
#(
    parameter int ROWS = LBR_ROWS
) (
    input logic clock,
    input logic resetn,
    input logic clk_en,
    input lbr_mem_port_t port_a,
    input lbr_mem_port_t port_b,
    output logic [LBR_ROW_W-1:0] rdata_a,
    output logic [LBR_ROW_W-1:0] rdata_b
);
    typedef struct packed {
        logic [LBR_ROW_W-1:0] rd_a;
        logic [LBR_ROW_W-1:0] rd_b;
    } lbr_mem_state_t;

    lbr_mem_state_t st_ff;
    lbr_mem_state_t nxt_st;
    logic [LBR_ROW_W-1:0] mem_ff [ROWS];

    function automatic logic [79:0] merge(input logic [79:0] old, input lbr_mem_port_t p);
        return (old & ~p.wmask) | (p.wdata & p.wmask);
    endfunction : merge

    // ==========================================================
    // read rows: read-first, a read beside a write sees the old row
    always_comb begin
        nxt_st = st_ff;
        if (port_a.rd) nxt_st.rd_a = mem_ff[port_a.row];
        if (port_b.rd) nxt_st.rd_b = mem_ff[port_b.row];
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // ==========================================================
    // writes: two writes to one row merge, port b on top
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (port_a.we) mem_ff[port_a.row] <= merge(mem_ff[port_a.row], port_a);
            if (port_b.we) begin
                mem_ff[port_b.row] <= merge((port_a.we && port_a.row == port_b.row) ?
                    merge(mem_ff[port_b.row], port_a) : mem_ff[port_b.row], port_b);
            end
        end
    end

    assign rdata_a = st_ff.rd_a;
    assign rdata_b = st_ff.rd_b;

    // ==========================================================
    // checks
    coll_write_a: assert property (@(posedge clock) disable iff (!resetn)
        (clk_en && port_a.we && port_b.rd && !port_b.we && port_a.row == port_b.row) |=>
        ((mem_ff[$past(port_a.row)] & $past(port_a.wmask)) ==
         ($past(port_a.wdata) & $past(port_a.wmask))))
        else $error("colliding write not stored");
    rd_new_a: assert property (@(posedge clock) disable iff (!resetn)
        (clk_en && port_a.we) ##1 (clk_en && port_b.rd && !port_a.we && !port_b.we &&
        port_b.row == $past(port_a.row)) |=>
        ((st_ff.rd_b & $past(port_a.wmask, 2)) == ($past(port_a.wdata, 2) & $past(port_a.wmask, 2))))
        else $error("read after write returned stale data");
    coll_seen_c: cover property (@(posedge clock) disable iff (!resetn)
        port_a.we && port_b.rd && port_a.row == port_b.row);
endmodule : lbr_mem

// ---- logic/lbr_large_block_ram.sv ----
// large block ram: two request ports, ecc, output registers, zeroize
//
// Overview of operation
// - array holds exactly 20480 bits
// - ecc protects words, bits interleaved across words
// - port widths 1,2,5,10,20,32,40; 33 with ecc
// - output registers with own enable and reset
// - read enable low: no access, output held
// - power switch turns the array off
// - dual-port only below 32 bits, ports independent
// - dual-port: read or write either port anywhere
// - colliding write stored, colliding read undefined
// - read after finished write returns new data
// - 32, 40 or 33 with ecc forces two-port
// - two-port: port a reads, port b writes
`timescale 1ns/100ps
module lbr_large_block_ram
    import lbr_pkg::*;
#(
    parameter int ROWS = LBR_ROWS
) (
    input logic clock,
    input logic resetn,
    input logic clk_en,
    input logic [7:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    input lbr_req_t a_req,
    input lbr_req_t b_req,
    input logic a_oreg_ce,
    input logic a_oreg_rst,
    input logic b_oreg_ce,
    input logic b_oreg_rst,
    output lbr_rsp_t a_rsp,
    output lbr_rsp_t b_rsp
);
    typedef struct packed {
        logic [LBR_CFG_USED-1:0] cfg;
        logic power;
        logic zbusy;
        logic [LBR_ROW_AW-1:0] zrow;
        logic sec_f;
        logic ded_f;
        logic ign_f;
        logic [31:0] rdata;
        lbr_req_t [1:0] inreg;
        logic [1:0] rv2;
        logic [1:0][LBR_LANE_W-1:0] lane2;
        logic [1:0] odd2;
        lbr_rsp_t [1:0] stg;
        lbr_rsp_t [1:0] dout;
    } lbr_state_t;

    lbr_state_t st_ff;
    lbr_state_t nxt_st;
    lbr_width_t [1:0] wid;
    logic ecc_on;
    logic two_port;
    logic acc_ok;
    logic cfg_bad;
    logic [1:0] oreg_on;
    logic [1:0] oreg_ce;
    logic [1:0] oreg_rst;
    logic [1:0] use_ecc;
    logic [1:0] ign_ev;
    lbr_mem_port_t [1:0] mp;
    logic [1:0][LBR_ROW_W-1:0] row_q;
    logic [1:0][LBR_WORD_W-1:0] gw;
    logic [1:0][34:0] dw;
    lbr_rsp_t [1:0] fresh;
    logic [31:0] stat_word;

    // ==========================================================
    // configuration decode
    assign wid[0] = lbr_width_t'(st_ff.cfg[LBR_CFG_WA_LSB +: 3]);
    assign wid[1] = lbr_width_t'(st_ff.cfg[LBR_CFG_WB_LSB +: 3]);
    assign ecc_on = st_ff.cfg[LBR_CFG_ECC_BIT];
    assign oreg_on = {st_ff.cfg[LBR_CFG_OREGB_BIT], st_ff.cfg[LBR_CFG_OREGA_BIT]};
    assign oreg_ce = {b_oreg_ce, a_oreg_ce};
    assign oreg_rst = {b_oreg_rst, a_oreg_rst};
    // a 33-bit width without ecc still runs two-port, stored as plain bits
    assign two_port = lbr_bits(wid[0]) >= LBR_TWO_PORT_MIN ||
                      lbr_bits(wid[1]) >= LBR_TWO_PORT_MIN;
    assign cfg_bad = !ecc_on && (wid[0] == LBR_W33 || wid[1] == LBR_W33);
    assign acc_ok = st_ff.power && !st_ff.zbusy;

    // ==========================================================
    // memory port drive from the registered requests
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            use_ecc[p] = ecc_on && wid[p] == LBR_W33;
            ign_ev[p] = two_port && ((p == 1 && st_ff.inreg[p].rd) ||
                                     (p == 0 && st_ff.inreg[p].wr));
            mp[p].rd = st_ff.inreg[p].rd && acc_ok && !(two_port && p == 1);
            mp[p].we = st_ff.inreg[p].wr && acc_ok && !(two_port && p == 0);
            mp[p].row = st_ff.inreg[p].addr[LBR_ADDR_W-1 -: LBR_ROW_AW];
            if (use_ecc[p]) begin
                mp[p].wmask = lbr_spread('1, st_ff.inreg[p].addr[LBR_LANE_W]);
                mp[p].wdata = lbr_spread(lbr_ecc_enc(st_ff.inreg[p].wdata[LBR_ECC_W-1:0]),
                                         st_ff.inreg[p].addr[LBR_LANE_W]);
            end else begin
                mp[p].wmask = lbr_spread(lbr_put_mask(wid[p], st_ff.inreg[p].addr[5:0],
                    st_ff.inreg[p].be), st_ff.inreg[p].addr[LBR_LANE_W]);
                mp[p].wdata = lbr_spread(lbr_put_data(wid[p], st_ff.inreg[p].addr[5:0],
                    st_ff.inreg[p].wdata), st_ff.inreg[p].addr[LBR_LANE_W]);
            end
        end
        // zeroize borrows port a, one row per cycle
        if (st_ff.zbusy) begin
            mp[0].rd = 1'b0;
            mp[0].we = 1'b1;
            mp[0].row = st_ff.zrow;
            mp[0].wmask = '1;
            mp[0].wdata = '0;
        end
    end

    lbr_mem #(
        .ROWS(ROWS)
    ) u_mem (
        .clock(clock),
        .resetn(resetn),
        .clk_en(clk_en),
        .port_a(mp[0]),
        .port_b(mp[1]),
        .rdata_a(row_q[0]),
        .rdata_b(row_q[1])
    );

    // ==========================================================
    // read row decode
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            gw[p] = lbr_gather(row_q[p], st_ff.odd2[p]);
            dw[p] = lbr_ecc_dec(gw[p]);
            fresh[p].valid = st_ff.rv2[p];
            if (use_ecc[p]) begin
                fresh[p].data = {7'h00, dw[p][LBR_ECC_W-1:0]};
                fresh[p].sec = dw[p][33] && st_ff.rv2[p];
                fresh[p].ded = dw[p][34] && st_ff.rv2[p];
            end else begin
                fresh[p].data = lbr_get(wid[p], st_ff.lane2[p], gw[p]);
                fresh[p].sec = 1'b0;
                fresh[p].ded = 1'b0;
            end
        end
    end

    always_comb begin
        stat_word = '0;
        stat_word[LBR_ST_TWO_BIT] = two_port;
        stat_word[LBR_ST_BUSY_BIT] = st_ff.zbusy;
        stat_word[LBR_ST_PWR_BIT] = st_ff.power;
        stat_word[LBR_ST_SEC_BIT] = st_ff.sec_f;
        stat_word[LBR_ST_DED_BIT] = st_ff.ded_f;
        stat_word[LBR_ST_IGN_BIT] = st_ff.ign_f;
        stat_word[LBR_ST_BAD_BIT] = cfg_bad;
    end

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                LBR_CFG_OFS: nxt_st.rdata = {23'h00_0000, st_ff.cfg};
                LBR_CTRL_OFS: nxt_st.rdata = {31'h0000_0000, st_ff.power};
                LBR_STAT_OFS: nxt_st.rdata = stat_word;
                default: nxt_st.rdata = '0;
            endcase
        end
        if (st_ff.zbusy) begin
            nxt_st.zrow = st_ff.zrow + 1'b1;
            if (st_ff.zrow == LBR_ROW_AW'(LBR_ZERO_CYCLES - 1)) nxt_st.zbusy = 1'b0;
        end
        if (reg_wr && reg_addr == LBR_CFG_OFS) nxt_st.cfg = reg_wdata[LBR_CFG_USED-1:0];
        if (reg_wr && reg_addr == LBR_CTRL_OFS) begin
            nxt_st.power = reg_wdata[LBR_CTRL_PWR_BIT];
            // contents are lost while off, so power-up clears the array
            if (reg_wdata[LBR_CTRL_PWR_BIT] &&
                (reg_wdata[LBR_CTRL_ZERO_BIT] || !st_ff.power)) begin
                nxt_st.zbusy = 1'b1;
                nxt_st.zrow = '0;
            end
            if (!reg_wdata[LBR_CTRL_PWR_BIT]) nxt_st.zbusy = 1'b0;
        end
        if (reg_wr && reg_addr == LBR_STAT_OFS) begin
            if (reg_wdata[LBR_ST_SEC_BIT]) nxt_st.sec_f = 1'b0;
            if (reg_wdata[LBR_ST_DED_BIT]) nxt_st.ded_f = 1'b0;
            if (reg_wdata[LBR_ST_IGN_BIT]) nxt_st.ign_f = 1'b0;
        end
        // events after the clear so a same-cycle event is kept
        if (fresh[0].sec || fresh[1].sec) nxt_st.sec_f = 1'b1;
        if (fresh[0].ded || fresh[1].ded) nxt_st.ded_f = 1'b1;
        if (ign_ev != 2'b00) nxt_st.ign_f = 1'b1;
        nxt_st.inreg[0] = a_req;
        nxt_st.inreg[1] = b_req;
        for (int p = 0; p < 2; p++) begin
            nxt_st.rv2[p] = mp[p].rd;
            nxt_st.lane2[p] = st_ff.inreg[p].addr[LBR_LANE_W-1:0];
            nxt_st.odd2[p] = st_ff.inreg[p].addr[LBR_LANE_W];
            nxt_st.stg[p] = fresh[p];
            if (oreg_rst[p]) begin
                nxt_st.dout[p] = '0;
            end else if (oreg_on[p]) begin
                if (oreg_ce[p] && st_ff.stg[p].valid) begin
                    nxt_st.dout[p] = st_ff.stg[p];
                end else begin
                    nxt_st.dout[p].valid = 1'b0;
                end
            end else if (fresh[p].valid) begin
                nxt_st.dout[p] = fresh[p];
            end else begin
                nxt_st.dout[p].valid = 1'b0;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            st_ff <= '0;
            st_ff.cfg <= LBR_CFG_RST;
            st_ff.power <= LBR_PWR_RST;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign a_rsp = st_ff.dout[0];
    assign b_rsp = st_ff.dout[1];

    // ==========================================================
    // checks
    logic [8:0] zcnt_ff;

    always_ff @(posedge clock) begin
        if (!resetn || !st_ff.zbusy) begin
            zcnt_ff <= '0;
        end else if (clk_en) begin
            zcnt_ff <= (st_ff.zrow == '0) ? 9'h001 : zcnt_ff + 1'b1;
        end
    end

    row_range_a: assert property (@(posedge clock) disable iff (!resetn)
        (mp[0].we || mp[1].we) |->
        (int'(mp[0].row) + 1) * LBR_ROW_W <= LBR_TOTAL_BITS &&
        (int'(mp[1].row) + 1) * LBR_ROW_W <= LBR_TOTAL_BITS)
        else $error("write row beyond the array");
    ecc_round_a: assert property (@(posedge clock) disable iff (!resetn)
        (mp[1].we && use_ecc[1]) |->
        lbr_ecc_dec(lbr_gather(mp[1].wdata, st_ff.inreg[1].addr[LBR_LANE_W])) ==
        {2'b00, st_ff.inreg[1].wdata[LBR_ECC_W-1:0]} &&
        (mp[1].wmask & lbr_spread('1, !st_ff.inreg[1].addr[LBR_LANE_W])) == '0)
        else $error("ecc code word does not decode back");
    rsp_width_a: assert property (@(posedge clock) disable iff (!resetn)
        a_rsp.valid |-> (a_rsp.data >> lbr_bits(wid[0])) == '0)
        else $error("read data wider than the port");
    oreg_rst_a: assert property (@(posedge clock) disable iff (!resetn)
        (clk_en && b_oreg_rst) |=> b_rsp == '0)
        else $error("output register reset ignored");
    hold_out_a: assert property (@(posedge clock) disable iff (!resetn)
        (clk_en && !st_ff.rv2[0] && !st_ff.stg[0].valid && !a_oreg_rst) |=>
        $stable(a_rsp.data) && !a_rsp.valid)
        else $error("output changed without a read");
    pwr_gate_a: assert property (@(posedge clock) disable iff (!resetn)
        !st_ff.power |-> !(mp[0].rd || mp[0].we || mp[1].rd || mp[1].we))
        else $error("array accessed while powered off");
    dual_indep_a: assert property (@(posedge clock) disable iff (!resetn)
        (!two_port && acc_ok) |->
        mp[1].rd == st_ff.inreg[1].rd && mp[0].we == st_ff.inreg[0].wr)
        else $error("dual-port access dropped");
    mode_sel_a: assert property (@(posedge clock) disable iff (!resetn)
        (wid[0] == LBR_W40 || wid[1] == LBR_W32 || (ecc_on && wid[0] == LBR_W33)) |->
        two_port)
        else $error("wide port did not force two-port");
    two_dir_a: assert property (@(posedge clock) disable iff (!resetn)
        (two_port && !st_ff.zbusy) |-> !mp[1].rd && !mp[0].we)
        else $error("two-port direction violated");
    in_reg_a: assert property (@(posedge clock) disable iff (!resetn)
        (clk_en && a_req.rd && !mp[0].rd) |=> (mp[0].rd || !acc_ok))
        else $error("registered read request lost");
    zero_len_a: assert property (@(posedge clock) disable iff (!resetn)
        ($fell(st_ff.zbusy) && st_ff.power) |-> zcnt_ff == LBR_ZERO_CYCLES)
        else $error("zeroize did not cover every row");
    ecc_fix_c: cover property (@(posedge clock) disable iff (!resetn) fresh[0].sec);
    zero_done_c: cover property (@(posedge clock) disable iff (!resetn)
        $fell(st_ff.zbusy) && st_ff.power);
    two_rd_c: cover property (@(posedge clock) disable iff (!resetn)
        two_port && a_rsp.valid);
endmodule : lbr_large_block_ram

// ---- dv/lbr_fab.sv ----
// user fabric model that drives both request ports of the block ram
`timescale 1ns/100ps
module lbr_fab
    import lbr_pkg::*;
(
    input lbr_req_t a_cmd,
    input lbr_req_t b_cmd,
    output lbr_req_t a_req,
    output lbr_req_t b_req
);
    // ==========================================
    // idle ports
    // an idle port shows inverted fields so the block never leans on stale values
    function automatic lbr_req_t idle(input lbr_req_t c);
        idle = ~c;
        idle.rd = 1'b0;
        idle.wr = 1'b0;
    endfunction : idle
    assign a_req = (a_cmd.rd | a_cmd.wr) ? a_cmd : idle(a_cmd);
    assign b_req = (b_cmd.rd | b_cmd.wr) ? b_cmd : idle(b_cmd);
endmodule : lbr_fab

// ---- dv/lbr_large_block_ram_tb.sv ----
// self-checking bench for the large block ram
`timescale 1ns/100ps
module lbr_large_block_ram_tb;
    import lbr_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    lbr_req_t a_cmd = '0;
    lbr_req_t b_cmd = '0;
    lbr_req_t a_req;
    lbr_req_t b_req;
    logic o_ce = 1'b1;
    logic o_rst = 1'b0;
    logic clk_en = 1'b1;
    lbr_rsp_t a_rsp;
    lbr_rsp_t b_rsp;
    int err_total = 0;
    int n_compared = 0;
    lbr_fab u_fab (.a_cmd(a_cmd), .b_cmd(b_cmd), .a_req(a_req), .b_req(b_req));
    lbr_large_block_ram u_dut (.clock(clock), .resetn(resetn), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .a_req(a_req), .b_req(b_req), .a_oreg_ce(o_ce),
        .a_oreg_rst(o_rst), .b_oreg_ce(o_ce), .b_oreg_rst(o_rst), .a_rsp(a_rsp),
        .b_rsp(b_rsp));
    initial begin
        forever #5 clock = ~clock;
    end
    // ==========================================
    // tasks
    task automatic chk(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rg(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= ad;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : rg
    function automatic lbr_req_t mk(input logic r, input logic [14:0] ad, input logic [39:0] d);
        mk = '{rd: r, wr: !r, addr: ad, wdata: d, be: 4'hf};
    endfunction : mk
    task automatic go(input lbr_req_t ca, input lbr_req_t cb);
        @(posedge clock);
        a_cmd <= ca;
        b_cmd <= cb;
        @(posedge clock);
        a_cmd[60:59] <= 2'b00;
        b_cmd[60:59] <= 2'b00;
    endtask : go
    task automatic rd(input logic pb, input logic [14:0] ad, input logic [39:0] e, input int lat);
        if (pb) go('0, mk(1'b1, ad, '0));
        else go(mk(1'b1, ad, '0), '0);
        repeat (lat - 1) @(posedge clock);
        #1;
        chk("valid", 40'h1, 40'(pb ? b_rsp.valid : a_rsp.valid));
        chk("data", e, pb ? b_rsp.data : a_rsp.data);
    endtask : rd
    task automatic stat(input int b, input logic e);
        rg(1'b0, LBR_STAT_OFS, '0);
        chk("stat", 40'(e), 40'(reg_rdata[b]));
    endtask : stat
    // zeroize runs a fixed span, so a fixed wait is exact here
    task automatic zero;
        rg(1'b1, LBR_CTRL_OFS, 32'h0000_0003);
        repeat (LBR_ZERO_CYCLES) @(posedge clock);
        stat(LBR_ST_BUSY_BIT, 1'b0);
    endtask : zero
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    // ==========================================
    // tests
    initial begin
        #100us;
        err_total++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clock);
        resetn <= 1'b1;
        // a write while the enable is low must leave no trace
        @(posedge clock);
        clk_en <= 1'b0;
        rg(1'b1, LBR_CFG_OFS, 32'h0000_01ff);
        @(posedge clock);
        clk_en <= 1'b1;
        rg(1'b0, LBR_CFG_OFS, '0);
        chk("cfg", '0, 40'(reg_rdata));
        stat(LBR_ST_PWR_BIT, 1'b1);
        zero();
        rg(1'b0, 8'h0c, '0);
        chk("unmapped", '0, 40'(reg_rdata));
        rg(1'b1, LBR_CFG_OFS, 32'h0000_001b);
        stat(LBR_ST_TWO_BIT, 1'b0);
        // colliding read result is undefined, so only the later reads count
        go(mk(1'b1, 15'h01c2, '0), mk(1'b0, 15'h01c2, 40'h00_0000_02a5));
        rd(1'b0, 15'h01c2, 40'h00_0000_02a5, 3);
        rd(1'b1, 15'h01c2, 40'h00_0000_02a5, 3);
        go(mk(1'b0, 15'h01c2, 40'h00_0000_0133), mk(1'b1, 15'h01c2, '0));
        rd(1'b1, 15'h01c2, 40'h00_0000_0133, 3);
        go(mk(1'b0, 15'h0203, 40'h00_0000_0155), '0);
        rd(1'b1, 15'h0203, 40'h00_0000_0155, 3);
        // write on a, read on b in the very next cycle
        @(posedge clock);
        a_cmd <= mk(1'b0, 15'h0241, 40'h00_0000_0099);
        @(posedge clock);
        a_cmd[60:59] <= 2'b00;
        b_cmd <= mk(1'b1, 15'h0241, '0);
        @(posedge clock);
        b_cmd[60:59] <= 2'b00;
        repeat (2) @(posedge clock);
        #1;
        chk("b2b", 40'h00_0000_0099, b_rsp.data);
        zero();
        rd(1'b0, 15'h01c2, '0, 3);
        rg(1'b1, LBR_CFG_OFS, 32'h0000_0036);
        stat(LBR_ST_TWO_BIT, 1'b1);
        go('0, mk(1'b0, 15'h0280, 40'h12_3456_789a));
        go(mk(1'b0, 15'h0280, 40'h00_0000_0000), '0);
        stat(LBR_ST_IGN_BIT, 1'b1);
        rd(1'b0, 15'h0280, 40'h12_3456_789a, 3);
        repeat (5) @(posedge clock);
        #1;
        chk("hold", 40'h12_3456_789a, a_rsp.data);
        rg(1'b1, LBR_CFG_OFS, 32'h0000_007f);
        go('0, mk(1'b0, 15'h0300, 40'h01_2345_6789));
        rd(1'b0, 15'h0300, 40'h01_2345_6789, 3);
        stat(LBR_ST_SEC_BIT, 1'b0);
        rg(1'b1, LBR_CFG_OFS, 32'h0000_00b6);
        rd(1'b0, 15'h0280, 40'h12_3456_789a, 4);
        @(posedge clock);
        o_rst <= 1'b1;
        @(posedge clock);
        o_rst <= 1'b0;
        #1;
        chk("oreg_rst", '0, a_rsp.data);
        rg(1'b1, LBR_CTRL_OFS, '0);
        stat(LBR_ST_PWR_BIT, 1'b0);
        finish_test();
    end
endmodule : lbr_large_block_ram_tb
